// File: rtl/dcce_pkg.sv
// Shared constants for the correction engine
package dcce_pkg;
  localparam int CHANNELS = 8;
  localparam int CODE_W = 16;
  // Register map, one aligned word each
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_BUSY = 8'h04;
  localparam logic [7:0] OFS_INPUT = 8'h20;
  localparam logic [7:0] OFS_GAIN = 8'h40;
  localparam logic [7:0] OFS_ZERO = 8'h60;
  localparam logic [7:0] OFS_OUT = 8'h80;
  // Field positions
  localparam int CFG_ENABLE_BIT = 0;
  localparam int BUSY_GLOBAL_BIT = 8;
  // Reset values
  localparam logic [15:0] GAIN_RESET = 16'h8000;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [15:0] INPUT_RESET = 16'h0000;
  localparam logic [15:0] OUT_RESET = 16'h0000;
  // Datapath constants
  localparam logic [16:0] GAIN_BIAS = 17'h0_8000;
  localparam logic [31:0] ROUND_HALF = 32'h0000_8000;
  // Correction time
  localparam int CORR_TIME_NS = 500;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CORR_CYCLES = CORR_TIME_NS / CLK_PERIOD_NS;
  localparam logic [4:0] CORR_LAST = 5'(CORR_CYCLES - 1);
  typedef enum logic [1:0] {
    DCCE_IDLE = 2'b01,
    DCCE_CALC = 2'b10
  } dcce_state_t;
endpackage

// File: rtl/dcce_engine.sv
// Eight-channel gain and zero correction engine behind an AHB-Lite slave
`timescale 1ns/100ps
module dcce_engine
  import dcce_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic busy_n_out,
  output logic busy_n_oe,
  output logic [CODE_W*CHANNELS-1:0] out_code,
  output logic group_a_active,
  output logic group_b_active
);

  // Address phase capture
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_pend_reg;
  logic [7:0] rd_addr_reg;
  wire addr_valid = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_valid && hwrite;
      rd_pend_reg <= addr_valid && !hwrite;
      wr_addr_reg <= haddr;
      rd_addr_reg <= haddr;
    end
  end

  // Zero wait-state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Write decode
  wire [2:0] wr_ch = wr_addr_reg[4:2];
  wire wr_cfg = wr_pend_reg && (wr_addr_reg == OFS_CONFIG);
  wire wr_in = wr_pend_reg && (wr_addr_reg[7:5] == OFS_INPUT[7:5]);
  wire wr_gain = wr_pend_reg && (wr_addr_reg[7:5] == OFS_GAIN[7:5]);
  wire wr_zero = wr_pend_reg && (wr_addr_reg[7:5] == OFS_ZERO[7:5]);
  wire wr_chan = wr_in || wr_gain || wr_zero;

  // Configuration
  logic enable_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= 1'b0;
    end else if (wr_cfg) begin
      enable_reg <= hwdata[CFG_ENABLE_BIT];
    end
  end

  // Per-channel storage
  logic [15:0] in_reg [CHANNELS];
  logic [15:0] gain_reg [CHANNELS];
  logic [15:0] zero_reg [CHANNELS];
  logic [15:0] out_reg [CHANNELS];
  logic [CHANNELS-1:0] pend_reg;
  logic [CHANNELS-1:0] done_mask;
  logic [15:0] result;
  logic [2:0] cur_ch_reg;

  // Engine state
  dcce_state_t state_reg;
  dcce_state_t state_next;
  logic [4:0] cnt_reg;
  logic [2:0] pick_ch;
  logic pick_any;
  wire calc_done = (state_reg == DCCE_CALC) && (cnt_reg == CORR_LAST);

  // Fixed priority pick, lowest index wins
  always_comb begin
    pick_ch = 3'd0;
    pick_any = 1'b0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick_ch = 3'(i);
        pick_any = 1'b1;
      end
    end
  end

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      wire sel = wr_chan && (wr_ch == 3'(c));
      wire fin = calc_done && (cur_ch_reg == 3'(c));
      assign done_mask[c] = fin;
      assign out_code[c*CODE_W +: CODE_W] = out_reg[c];

      // Trim and code storage
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          in_reg[c] <= INPUT_RESET;
          gain_reg[c] <= GAIN_RESET;
          zero_reg[c] <= ZERO_RESET;
        end else begin
          if (sel && wr_in) begin
            in_reg[c] <= hwdata[15:0];
          end
          if (sel && wr_gain) begin
            gain_reg[c] <= hwdata[15:0];
          end
          if (sel && wr_zero) begin
            zero_reg[c] <= hwdata[15:0];
          end
        end
      end

      // Output register: bypass when disabled, else engine result
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          out_reg[c] <= OUT_RESET;
        end else if (!enable_reg && sel && wr_in) begin
          out_reg[c] <= hwdata[15:0];
        end else if (fin) begin
          out_reg[c] <= result;
        end
      end

      // Pending flag, a new write wins over completion
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pend_reg[c] <= 1'b0;
        end else if (!enable_reg) begin
          pend_reg[c] <= 1'b0;
        end else if (sel) begin
          pend_reg[c] <= 1'b1;
        end else if (fin) begin
          pend_reg[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // Datapath on current channel, latest register contents
  logic [16:0] gain_coef;
  logic [32:0] product;
  logic [17:0] scaled;
  logic signed [18:0] sum;
  always_comb begin
    gain_coef = {1'b0, gain_reg[cur_ch_reg]} + GAIN_BIAS;
    product = {17'h0_0000, in_reg[cur_ch_reg]} * {16'h0000, gain_coef};
    scaled = 18'((product + {1'b0, ROUND_HALF}) >> 16);
    sum = signed'({1'b0, scaled}) + 19'(signed'(zero_reg[cur_ch_reg]));
    if (sum < 0) begin
      result = 16'h0000;
    end else if (sum > 19'sh0_FFFF) begin
      result = 16'hFFFF;
    end else begin
      result = sum[15:0];
    end
  end

  // Sequencer: one channel at a time
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DCCE_IDLE: begin
        if (enable_reg && pick_any) begin
          state_next = DCCE_CALC;
        end
      end
      DCCE_CALC: begin
        if (!enable_reg || calc_done) begin
          state_next = DCCE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= DCCE_IDLE;
      cnt_reg <= 5'd0;
      cur_ch_reg <= 3'd0;
    end else begin
      state_reg <= state_next;
      if (state_reg == DCCE_IDLE) begin
        cnt_reg <= 5'd0;
        cur_ch_reg <= pick_ch;
      end else begin
        cnt_reg <= cnt_reg + 5'd1;
      end
    end
  end

  // Activity flag and open-drain busy
  wire active = enable_reg && (state_reg == DCCE_CALC);
  assign busy_n_out = 1'b0;
  assign busy_n_oe = active;
  assign group_a_active = active && !cur_ch_reg[2];
  assign group_b_active = active && cur_ch_reg[2];

  // Read mux
  wire [2:0] rd_ch = rd_addr_reg[4:2];
  wire [31:0] rd_word =
    (rd_addr_reg == OFS_CONFIG) ? {31'h0, enable_reg} :
    (rd_addr_reg == OFS_BUSY) ? {23'h0, active, pend_reg} :
    (rd_addr_reg[7:5] == OFS_INPUT[7:5]) ? {16'h0, in_reg[rd_ch]} :
    (rd_addr_reg[7:5] == OFS_GAIN[7:5]) ? {16'h0, gain_reg[rd_ch]} :
    (rd_addr_reg[7:5] == OFS_ZERO[7:5]) ? {16'h0, zero_reg[rd_ch]} :
    (rd_addr_reg[7:5] == OFS_OUT[7:5]) ? {16'h0, out_reg[rd_ch]} : 32'h0000_0000;
  assign hrdata = rd_pend_reg ? rd_word : 32'h0000_0000;

endmodule

// File: testbench/dcce_engine_chk.sv
// Port assertions for the correction engine
`timescale 1ns/100ps
module dcce_engine_chk
  import dcce_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy_n_out,
  input wire logic busy_n_oe,
  input wire logic [CODE_W*CHANNELS-1:0] out_code,
  input wire logic group_a_active,
  input wire logic group_b_active
);
  logic cfg_ph_reg;
  logic en_reg;
  logic [4:0] run_reg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of the enable bit and length of the current run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ph_reg <= 1'b0;
      en_reg <= 1'b0;
      run_reg <= 5'd0;
    end else begin
      cfg_ph_reg <= hsel && hready && htrans[1] && hwrite && haddr == OFS_CONFIG;
      en_reg <= cfg_ph_reg ? hwdata[CFG_ENABLE_BIT] : en_reg;
      run_reg <= !busy_n_oe ? 5'd0 : run_reg == 5'd20 ? 5'd1 : run_reg + 5'd1;
    end
  end
  // Start of a run and its minimum hold
  sequence s_run_start;
    $rose(busy_n_oe);
  endsequence
  sequence s_run_hold;
    busy_n_oe[*8];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not OKAY");
  a_pin_drive: assert property (busy_n_oe |-> !busy_n_out)
    else $error("busy pin not low");
  a_one_group: assert property (!(group_a_active && group_b_active))
    else $error("two groups busy");
  a_group_busy: assert property ((group_a_active || group_b_active) == busy_n_oe)
    else $error("group flags off busy");
  a_off_quiet: assert property (!en_reg && !$past(en_reg) |-> !busy_n_oe)
    else $error("busy while disabled");
  a_run_min: assert property (s_run_start |-> s_run_hold)
    else $error("run too short");
  a_run_len: assert property ($fell(busy_n_oe) && en_reg |-> run_reg == 5'd20)
    else $error("run not 20 cycles");
  a_out_timed: assert property ($changed(out_code) && en_reg && $past(en_reg)
    |-> run_reg == 5'd20)
    else $error("output updated off time");
  a_out_still: assert property (en_reg && !busy_n_oe && !$past(busy_n_oe)
    |-> $stable(out_code))
    else $error("output moved while idle");
  a_rd_width: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
endmodule
bind dcce_engine dcce_engine_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .busy_n_out,
  .busy_n_oe, .out_code, .group_a_active, .group_b_active);

// File: testbench/dcce_host.sv
// Host model: bus master and busy line pull-up
`timescale 1ns/100ps
module dcce_host (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic busy_n_out,
  input wire logic busy_n_oe,
  output logic [7:0] haddr = 8'h00,
  output logic [1:0] htrans = 2'b00,
  output logic hwrite = 1'b0,
  output logic [31:0] hwdata = 32'h0000_0000,
  output wire logic busy_pin
);
  // Line pulled high when released
  assign busy_pin = busy_n_oe ? busy_n_out : 1'b1;
  // One word transfer, each phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
endmodule

// File: testbench/tb_dcce_engine.sv
// Bench for the correction engine
`timescale 1ns/100ps
module tb_dcce_engine;
  import dcce_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite, hreadyout, hresp, busy_n_out, busy_n_oe, busy_pin, ga, gb;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  logic [CODE_W*CHANNELS-1:0] out_code;
  logic [23:0] wseq [8] = '{24'h64_0010, 24'h40_FFFF, 24'h60_7FFF, 24'h20_FFFF,
    24'h5C_0000, 24'h3C_4000, 24'h7C_F000, 24'h28_1234};
  int err_total = 0;
  int comparisons = 0;
  always #12.5 hclk = ~hclk;
  dcce_engine dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .busy_n_out, .busy_n_oe, .out_code, .group_a_active(ga), .group_b_active(gb));
  dcce_host host (.hclk, .hreadyout, .hrdata, .busy_n_out, .busy_n_oe, .haddr,
    .htrans, .hwrite, .hwdata, .busy_pin);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, {16'h0000, d}, q);
  endtask
  // Poll until the masked pending bits clear
  task automatic wait_clr(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      rd(OFS_BUSY);
      n++;
    end while ((q[7:0] & m) !== 8'h00 && n < 99);
  endtask
  task automatic outc(input int c, input logic [15:0] e);
    rd(8'(OFS_OUT + 4 * c));
    chk(q, {16'h0000, e});
    chk({16'h0000, out_code[16*c+:16]}, {16'h0000, e});
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_GAIN);
    chk(q, 32'h0000_8000);
    rd(OFS_CONFIG);
    chk(q, 32'h0000_0000);
    // Disabled: direct copy, trims only stored
    wr(OFS_INPUT + 8'h08, 16'h1234);
    wr(OFS_GAIN + 8'h08, 16'h4000);
    rd(OFS_BUSY);
    chk({q[31:1], busy_pin}, 32'h0000_0001);
    outc(2, 16'h1234);
    rd(OFS_GAIN + 8'h08);
    chk(q, 32'h0000_4000);
    // Enabled: every write recomputes its channel
    wr(OFS_CONFIG, 16'h0001);
    foreach (wseq[i]) begin
      wr(wseq[i][23:16], wseq[i][15:0]);
      wait_clr(8'hFF);
    end
    outc(2, 16'h0DA7);
    outc(0, 16'hFFFF);
    outc(7, 16'h1000);
    // Three channels pending at once
    wr(OFS_INPUT + 8'h18, 16'h0600);
    wr(OFS_INPUT + 8'h0C, 16'h0300);
    wr(OFS_INPUT + 8'h04, 16'h0100);
    rd(OFS_BUSY);
    chk({q[31:1], gb}, 32'h0000_014B);
    wait_clr(8'h40);
    // Let the engine pass its one idle cycle before looking at the group flag
    @(posedge hclk);
    chk({24'h00_0000, q[7:1], ga}, 32'h0000_000B);
    wait_clr(8'h02);
    chk({24'h00_0000, q[7:0]}, 32'h0000_0008);
    wait_clr(8'hFF);
    outc(1, 16'h0110);
    outc(3, 16'h0300);
    outc(6, 16'h0600);
    // Unmapped place, then back to pass-through
    wr(8'h1C, 16'hFFFF);
    rd(8'h1C);
    chk(q, 32'h0000_0000);
    wr(OFS_CONFIG, 16'h0000);
    wr(OFS_INPUT + 8'h04, 16'hABCD);
    outc(1, 16'hABCD);
    end_of_test();
  end
endmodule
